//--- verilog/tsr_readout.sv
// Purpose: conversion control, formatting and serial slave
// Assumes: converter strobe on mclk; open-drain link pins
// Notes: serial slave runs on link_clk and oversamples scl/sda
`timescale 1ns/1ps
module tsr_readout #(
    parameter bit POS_ONLY = 1'b0
) (
    input  wire logic          mclk,             // system clock, 200 MHz
    input  wire logic          rst_n,            // async reset, active low
    input  wire logic          link_clk,         // link oversampling clock
    input  wire logic          hw_sleep_pin_n,   // hardware standby pin
    input  wire tsr_pkg::tsr_adc_t adc_in,       // converter result
    output logic               adc_start,        // one-cycle conversion start
    output logic               adc_abort,        // one-cycle conversion abort
    output logic               alarm_open,       // open-diode alarm condition
    input  wire logic          scl_in,           // serial clock pin level
    input  wire logic          sda_in,           // serial data pin level
    output logic               sda_out,          // serial data drive value
    output logic               sda_oe            // high while pulling data low
);
    import tsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // mclk domain: synchronisers
    logic hw_pin_m1, hw_pin_m2;
    logic hw_sleep_pin_n_m1, hw_sleep_pin_n_m2, hw_sleep_pin_n_m3;
    logic ext_m1, ext_m2;
    logic os_m1, os_m2, os_m3;
    logic ack_m1, ack_m2;
    logic sw_hw_sleep_pin_n_cfg;                           // link-domain config bit
    logic ext_ok_cfg;                            // link-domain slow rate flag
    logic os_tog_reg;                            // link-domain one-shot toggle
    logic ack_tog_reg;                           // link-domain snapshot ack

    // pin and cross-domain levels, two flops each, three for the edge-detected config bit and one-shot toggle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hw_pin_m1 <= 1'b0;  // standby until seen
            hw_pin_m2 <= 1'b0;
            hw_sleep_pin_n_m1   <= 1'b0;
            hw_sleep_pin_n_m2   <= 1'b0;
            hw_sleep_pin_n_m3   <= 1'b0;
            ext_m1    <= 1'b0;
            ext_m2    <= 1'b0;
            os_m1     <= 1'b0;
            os_m2     <= 1'b0;
            os_m3     <= 1'b0;
            ack_m1    <= 1'b0;
            ack_m2    <= 1'b0;
        end else begin
            hw_pin_m1 <= hw_sleep_pin_n;
            hw_pin_m2 <= hw_pin_m1;
            hw_sleep_pin_n_m1   <= sw_hw_sleep_pin_n_cfg;
            hw_sleep_pin_n_m2   <= hw_sleep_pin_n_m1;
            hw_sleep_pin_n_m3   <= hw_sleep_pin_n_m2;
            ext_m1    <= ext_ok_cfg;
            ext_m2    <= ext_m1;
            os_m1     <= os_tog_reg;
            os_m2     <= os_m1;
            os_m3     <= os_m2;
            ack_m1    <= ack_tog_reg;
            ack_m2    <= ack_m1;
        end
    end

    logic hw_hw_sleep_pin_n, sw_hw_sleep_pin_n_rise, oneshot_req;
    assign hw_hw_sleep_pin_n      = ~hw_pin_m2;
    assign sw_hw_sleep_pin_n_rise = hw_sleep_pin_n_m2 & ~hw_sleep_pin_n_m3;
    assign oneshot_req  = os_m2 ^ os_m3;

    ////////////////////////////////////////////////////////////////////////
    // mclk domain: conversion control
    tsr_conv_st_t conv_reg;
    logic         start_ok, abort_now;

    // autoconvert when running; one-shot only if pin high and idle
    assign start_ok  = ~hw_hw_sleep_pin_n & (~hw_sleep_pin_n_m2 | oneshot_req);
    // pin low aborts; so does a new software standby
    assign abort_now = hw_hw_sleep_pin_n | sw_hw_sleep_pin_n_rise;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            conv_reg  <= CV_IDLE;
            adc_start <= 1'b0;
            adc_abort <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            adc_abort <= 1'b0;
            case (conv_reg)
                CV_IDLE: begin
                    if (start_ok) begin
                        conv_reg  <= CV_RUN;
                        adc_start <= 1'b1;
                    end
                end
                CV_RUN: begin
                    if (abort_now) begin
                        conv_reg  <= CV_IDLE;
                        adc_abort <= 1'b1;
                    end else if (adc_in.done) begin
                        conv_reg  <= CV_IDLE;
                    end
                end
                default: conv_reg <= CV_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mclk domain: result formatting and capture
    logic       capture;
    logic [7:0] loc_main_next, rem_main_next, loc_frac_next, rem_frac_next;
    logic       rem_fault;

    assign capture   = (conv_reg == CV_RUN) & ~abort_now & adc_in.done;
    assign rem_fault = adc_in.fault_open | adc_in.fault_short;

    // 11-bit result already saturates at 127.875; variant clamps negatives
    always_comb begin
        loc_main_next = adc_in.local_res[10:3];
        loc_frac_next = {adc_in.local_res[2:0], 5'h00};
        rem_main_next = adc_in.remote_res[10:3];
        rem_frac_next = {adc_in.remote_res[2:0], 5'h00};
        if (POS_ONLY && adc_in.local_res[10]) begin
            loc_main_next = TEMP_FLOOR;
            loc_frac_next = 8'h00;
        end
        if (POS_ONLY && adc_in.remote_res[10]) begin
            rem_main_next = TEMP_FLOOR;
            rem_frac_next = 8'h00;
        end
        if (rem_fault) begin
            rem_main_next = TEMP_FLOOR;
            rem_frac_next = 8'h00;
        end
        if (!ext_m2) begin
            loc_frac_next = 8'h00;
            rem_frac_next = 8'h00;
        end
    end

    tsr_snap_t live_reg;

    // both channels and both widths load on the same edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            live_reg <= '0;
        end else begin
            live_reg.busy <= (conv_reg == CV_RUN);
            if (capture) begin
                live_reg.loc_main  <= loc_main_next;
                live_reg.rem_main  <= rem_main_next;
                live_reg.loc_frac  <= loc_frac_next;
                live_reg.rem_frac  <= rem_frac_next;
                live_reg.open_flag <= adc_in.fault_open;
            end
        end
    end

    assign alarm_open = live_reg.open_flag;

    ////////////////////////////////////////////////////////////////////////
    // mclk -> link snapshot handshake
    tsr_snap_t snap_reg;
    logic      req_tog_reg;

    // a new snapshot is offered only after the last one was taken
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            snap_reg    <= '0;
            req_tog_reg <= 1'b0;
        end else if ((req_tog_reg == ack_m2) && (snap_reg != live_reg)) begin
            snap_reg    <= live_reg;
            req_tog_reg <= ~req_tog_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: pin and request synchronisers
    logic scl_l1, scl_l2, scl_l3;
    logic sda_l1, sda_l2, sda_l3;
    logic req_l1, req_l2;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_l1 <= 1'b1;
            scl_l2 <= 1'b1;
            scl_l3 <= 1'b1;
            sda_l1 <= 1'b1;
            sda_l2 <= 1'b1;
            sda_l3 <= 1'b1;
            req_l1 <= 1'b0;
            req_l2 <= 1'b0;
        end else begin
            scl_l1 <= scl_in;
            scl_l2 <= scl_l1;
            scl_l3 <= scl_l2;
            sda_l1 <= sda_in;
            sda_l2 <= sda_l1;
            sda_l3 <= sda_l2;
            req_l1 <= req_tog_reg;
            req_l2 <= req_l1;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_l2 & ~scl_l3;
    assign scl_fall  = ~scl_l2 & scl_l3;
    assign bus_start = scl_l2 & scl_l3 & sda_l3 & ~sda_l2;
    assign bus_stop  = scl_l2 & scl_l3 & ~sda_l3 & sda_l2;

    // snapshot taken when the request toggle moves
    tsr_snap_t view_reg;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            view_reg    <= '0;
            ack_tog_reg <= 1'b0;
        end else if (req_l2 != ack_tog_reg) begin
            view_reg    <= snap_reg;
            ack_tog_reg <= req_l2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: serial slave
    tsr_link_st_t lk_reg;
    logic [7:0]   sr_reg;
    logic [3:0]   cnt_reg;
    logic         rd_reg;
    logic [7:0]   tx_reg;
    logic [7:0]   cmd_reg;
    logic [7:0]   cfg_reg;
    logic [7:0]   rate_reg;
    logic [7:0]   rd_mux;
    logic         byte_done;

    assign byte_done = scl_fall & (cnt_reg == BITS_PER_BYTE);

    // register read select, answered in any standby state
    always_comb begin
        if (cmd_reg == OFS_LOC_MAIN) begin
            rd_mux = view_reg.loc_main;
        end else if (cmd_reg == OFS_REM_MAIN) begin
            rd_mux = view_reg.rem_main;
        end else if (cmd_reg == OFS_STATUS) begin
            rd_mux = 8'h00;
            rd_mux[STAT_BUSY_BIT] = view_reg.busy;
            rd_mux[STAT_OPEN_BIT] = view_reg.open_flag;
        end else if (cmd_reg == OFS_CFG_RD) begin
            rd_mux = cfg_reg;
        end else if (cmd_reg == OFS_RATE_RD) begin
            rd_mux = rate_reg;
        end else if (cmd_reg == OFS_REM_FRAC) begin
            rd_mux = view_reg.rem_frac;
        end else if (cmd_reg == OFS_LOC_FRAC) begin
            rd_mux = view_reg.loc_frac;
        end else if (cmd_reg == OFS_MFR_ID) begin
            rd_mux = MFR_ID;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // transfer sequencing
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_reg  <= LK_IDLE;
            sr_reg  <= 8'h00;
            cnt_reg <= 4'h0;
            rd_reg  <= 1'b0;
            tx_reg  <= 8'h00;
        end else if (bus_start) begin
            lk_reg  <= LK_ADDR;
            cnt_reg <= 4'h0;
        end else if (bus_stop) begin
            lk_reg  <= LK_IDLE;
        end else begin
            if (scl_rise) begin
                sr_reg  <= {sr_reg[6:0], sda_l2};
                cnt_reg <= cnt_reg + 4'h1;
            end
            case (lk_reg)
                LK_ADDR: begin
                    if (byte_done) begin
                        rd_reg <= sr_reg[0];
                        if (sr_reg[7:1] == SLAVE_ADDR) begin
                            lk_reg <= LK_AACK;
                        end else begin
                            lk_reg <= LK_IDLE;
                        end
                    end
                end
                LK_AACK: begin
                    if (scl_fall) begin
                        cnt_reg <= 4'h0;
                        if (rd_reg) begin
                            lk_reg <= LK_RDAT;
                            tx_reg <= rd_mux;
                        end else begin
                            lk_reg <= LK_CMD;
                        end
                    end
                end
                LK_CMD: begin
                    if (byte_done) begin
                        lk_reg <= LK_CACK;
                    end
                end
                LK_CACK: begin
                    if (scl_fall) begin
                        cnt_reg <= 4'h0;
                        lk_reg  <= LK_WDAT;
                    end
                end
                LK_WDAT: begin
                    if (byte_done) begin
                        lk_reg <= LK_WACK;
                    end
                end
                LK_WACK: begin
                    if (scl_fall) begin
                        lk_reg <= LK_IDLE;
                    end
                end
                LK_RDAT: begin
                    if (byte_done) begin
                        lk_reg <= LK_RACK;
                    end else if (scl_fall) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                    end
                end
                LK_RACK: begin
                    if (scl_fall) begin
                        lk_reg <= LK_IDLE;
                    end
                end
                default: lk_reg <= LK_IDLE;
            endcase
        end
    end

    // command index, config, rate and one-shot toggle
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg    <= CMD_RST;
            cfg_reg    <= CFG_RST;
            rate_reg   <= RATE_RST;
            os_tog_reg <= 1'b0;
        end else if ((lk_reg == LK_CMD) && byte_done && !bus_start && !bus_stop) begin
            cmd_reg <= sr_reg;
            if (sr_reg == OFS_ONESHOT) begin
                os_tog_reg <= ~os_tog_reg;
            end
        end else if ((lk_reg == LK_WDAT) && byte_done && !bus_start && !bus_stop) begin
            if (cmd_reg == OFS_CFG_WR) begin
                cfg_reg <= sr_reg & CFG_WR_MASK;
            end else if (cmd_reg == OFS_RATE_WR) begin
                rate_reg <= sr_reg;
            end
        end
    end

    assign sw_hw_sleep_pin_n_cfg = cfg_reg[CFG_HW_SLEEP_PIN_N_BIT];
    assign ext_ok_cfg  = (rate_reg <= RATE_EXT_MAX);

    // data line drive, changed only while scl is low
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
        end else if (bus_start || bus_stop) begin
            sda_oe <= 1'b0;
        end else if (byte_done && (lk_reg == LK_ADDR)) begin
            sda_oe <= (sr_reg[7:1] == SLAVE_ADDR);
        end else if (byte_done && ((lk_reg == LK_CMD) || (lk_reg == LK_WDAT))) begin
            sda_oe <= 1'b1;
        end else if (scl_fall && (lk_reg == LK_AACK) && rd_reg) begin
            sda_oe <= ~rd_mux[7];
        end else if (scl_fall && (lk_reg == LK_RDAT) && !byte_done) begin
            sda_oe <= ~tx_reg[6];
        end else if (scl_fall) begin
            sda_oe <= 1'b0;
        end
    end

    assign sda_out = 1'b0;
endmodule

//--- verilog/tsr_pkg.sv
// Purpose: constants and types for the readout controller
// Assumes: clocks mclk and link_clk
// Notes: offsets are the command codes
// Behaviour
// - config bit 6 set enters software standby
// - hardware standby while sleep pin low
// - standby keeps registers, bus stays alive
// - one-shot runs in sw standby, ignored hw
// - sleep pin low overrides software requests
// - standby during conversion aborts, keeps data
// - one slave address reaches everything
// - write/read/send/receive byte transfers only
// - receive byte returns last selected register
// - main registers 8-bit two's complement, 1C
// - serial data shifted out MSB first
// - fraction bits valid at 4Hz or slower
// - main and fraction update together
// - command 0fh starts one conversion
// - busy flag high while converting
// - rate resets to 16Hz, fractions invalid
// - diode fault loads 80h into remote
// - open fault sets status bit 2, alarm
// - no fault reported before first conversion
// - saturate high; positive-only variant clamps negatives
// - each conversion does both channels
// - one-shot during conversion is ignored
// - command index resets to 00h
package tsr_pkg;
    // command codes / register offsets
    localparam logic [7:0] OFS_LOC_MAIN  = 8'h00;
    localparam logic [7:0] OFS_REM_MAIN  = 8'h01;
    localparam logic [7:0] OFS_STATUS    = 8'h02;
    localparam logic [7:0] OFS_CFG_RD    = 8'h03;
    localparam logic [7:0] OFS_RATE_RD   = 8'h04;
    localparam logic [7:0] OFS_CFG_WR    = 8'h09;
    localparam logic [7:0] OFS_RATE_WR   = 8'h0a;
    localparam logic [7:0] OFS_ONESHOT   = 8'h0f;
    localparam logic [7:0] OFS_REM_FRAC  = 8'h10;
    localparam logic [7:0] OFS_LOC_FRAC  = 8'h11;
    localparam logic [7:0] OFS_MFR_ID    = 8'hfe;
    // reset values
    localparam logic [7:0] CMD_RST       = 8'h00;
    localparam logic [7:0] CFG_RST       = 8'h20;
    localparam logic [7:0] RATE_RST      = 8'h08;
    localparam logic [7:0] CFG_WR_MASK   = 8'he0;
    // fields
    localparam int         CFG_HW_SLEEP_PIN_N_BIT  = 6;
    localparam int         STAT_BUSY_BIT = 7;
    localparam int         STAT_OPEN_BIT = 2;
    localparam logic [7:0] RATE_EXT_MAX  = 8'h06;
    localparam logic [7:0] TEMP_FLOOR    = 8'h80;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] SLAVE_ADDR    = 7'h4c;
    localparam logic [7:0] MFR_ID        = 8'h5a; // arbitrary value

    typedef enum logic [3:0] {
        LK_IDLE  = 4'b0000,
        LK_ADDR  = 4'b0001,
        LK_AACK  = 4'b0010,
        LK_CMD   = 4'b0011,
        LK_CACK  = 4'b0100,
        LK_WDAT  = 4'b0101,
        LK_WACK  = 4'b0110,
        LK_RDAT  = 4'b0111,
        LK_RACK  = 4'b1000
    } tsr_link_st_t;

    typedef enum logic [0:0] {
        CV_IDLE = 1'b0,
        CV_RUN  = 1'b1
    } tsr_conv_st_t;

    typedef struct packed {
        logic        done;
        logic        fault_open;
        logic        fault_short;
        logic [10:0] local_res;
        logic [10:0] remote_res;
    } tsr_adc_t;

    typedef struct packed {
        logic       busy;
        logic       open_flag;
        logic [7:0] loc_main;
        logic [7:0] rem_main;
        logic [7:0] loc_frac;
        logic [7:0] rem_frac;
    } tsr_snap_t;
endpackage

//--- sim/tsr_readout_sva.sv
// Purpose: temporal checks on the readout ports
// Assumes: done comes only while converting
// Notes: run_reg mirrors the conversion state
`timescale 1ns/1ps
module tsr_readout_sva (
    input wire logic              mclk,           // system clock
    input wire logic              rst_n,          // async reset
    input wire logic              link_clk,       // link clock
    input wire logic              hw_sleep_pin_n, // standby pin
    input wire tsr_pkg::tsr_adc_t adc_in,         // converter input
    input wire logic              adc_start,      // start pulse
    input wire logic              adc_abort,      // abort pulse
    input wire logic              alarm_open,     // open alarm
    input wire logic              scl_in,         // clock pin
    input wire logic              sda_in,         // data pin
    input wire logic              sda_out,        // data drive value
    input wire logic              sda_oe          // data enable
);
    import tsr_pkg::*;
    logic run_reg;
    ////////////////////////////////////////
    // conversion in flight
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_reg <= 1'b0;
        end else if (adc_start) begin
            run_reg <= 1'b1;
        end else if (adc_in.done || adc_abort) begin
            run_reg <= 1'b0;
        end
    end
    ////////////////////////////////////////
    chk_start_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
        adc_start |=> !adc_start) else $error("start pulse too long");
    chk_no_start_busy: assert property (@(posedge mclk) disable iff (!rst_n)
        run_reg |-> !adc_start) else $error("start while converting");
    chk_pin_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
        !hw_sleep_pin_n [*5] |-> !adc_start) else $error("start while pin low");
    chk_pin_aborts: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(hw_sleep_pin_n) && run_reg |-> ##[1:6] (adc_abort || adc_in.done))
        else $error("pin low did not abort");
    chk_abort_in_run: assert property (@(posedge mclk) disable iff (!rst_n)
        adc_abort |-> run_reg) else $error("abort while idle");
    chk_abort_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        adc_abort && !hw_sleep_pin_n |=> !adc_start [*3]) else $error("restart after abort");
    chk_alarm_on_done: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(alarm_open) |-> $past(adc_in.done) && alarm_open == $past(adc_in.fault_open))
        else $error("alarm changed without done");
    chk_oe_scl_low: assert property (@(posedge link_clk) disable iff (!rst_n)
        $changed(sda_oe) |-> !scl_in) else $error("data moved while clock high");
endmodule
bind tsr_readout tsr_readout_sva u_sva (.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
    .hw_sleep_pin_n(hw_sleep_pin_n), .adc_in(adc_in), .adc_start(adc_start),
    .adc_abort(adc_abort), .alarm_open(alarm_open), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe));

//--- sim/tsr_host_model.sv
// Purpose: serial bus host model for the sensor link
// Assumes: pull-ups resolved in the bench
// Notes: a quarter is three link clocks
`timescale 1ns/1ps
module tsr_host_model (
    input  wire logic lclk,    // host bit timing
    input  wire logic sda,     // resolved data wire
    output logic      scl_low, // host pulls clock low
    output logic      sda_low  // host pulls data low
);
    import tsr_pkg::*;
    int nacks;
    ////////////////////////////////////////
    // wires released at time zero
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        nacks = 0;
    end
    // bit phase and framing
    task automatic qtr;
        repeat (3) @(posedge lclk);
    endtask
    task automatic start;
        sda_low <= 1'b0;
        qtr;
        scl_low <= 1'b0;
        qtr;
        sda_low <= 1'b1;
        qtr;
        scl_low <= 1'b1;
        qtr;
    endtask
    task automatic stop;
        sda_low <= 1'b1;
        qtr;
        scl_low <= 1'b0;
        qtr;
        sda_low <= 1'b0;
        qtr;
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_low <= !b;
        qtr;
        scl_low <= 1'b0;
        qtr;
        r = sda;
        scl_low <= 1'b1;
        qtr;
    endtask
    // byte msb first, then ack
    task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] r,
                         output logic a);
        for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
        xbit(ab, a);
    endtask
    task automatic tx(input logic [7:0] d);
        logic [7:0] x;
        logic       a;
        xbyte(d, 1'b1, x, a);
        nacks += int'(a);
    endtask
    // write byte, or send byte without data
    task automatic send(input logic [7:0] c, input logic [7:0] d, input bit wd);
        start;
        tx({SLAVE_ADDR, 1'b0});
        tx(c);
        if (wd) tx(d);
        stop;
    endtask
    // read byte selects, receive byte reuses
    task automatic rd(input logic [7:0] c, output logic [7:0] r);
        logic a;
        start;
        tx({SLAVE_ADDR, 1'b0});
        tx(c);
        start;
        tx({SLAVE_ADDR, 1'b1});
        xbyte(8'hff, 1'b1, r, a);
        stop;
    endtask
    task automatic rx(output logic [7:0] r);
        logic a;
        start;
        tx({SLAVE_ADDR, 1'b1});
        xbyte(8'hff, 1'b1, r, a);
        stop;
    endtask
endmodule

//--- sim/tsr_readout_tb.sv
// Purpose: self-checking bench for the readout
// Assumes: converter modelled here, host model on the serial pins
// Notes: expectations come from the integer model
`timescale 1ns/1ps
module tsr_readout_tb;
    import tsr_pkg::*;
    logic       mclk, rst_n, link_clk, pin_n, scl_low, sda_low, scl, sda;
    logic       adc_start, adc_abort, alarm_open, sda_out, sda_oe;
    tsr_adc_t   adc_in;
    logic [7:0] r;
    int         seed, cnt, conv_len, starts, aborts, failures, compares, cyc, rate, n0;
    int         expv [4];
    int         exp_open;
    logic [7:0] offs [4] = '{OFS_LOC_MAIN, OFS_REM_MAIN, OFS_LOC_FRAC, OFS_REM_FRAC};
    ////////////////////////////////////////
    // clocks, link clock offset in phase
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // open-drain wires with pull-ups
    assign scl = !scl_low;
    assign sda = !(sda_low || sda_oe);
    tsr_readout u_tsr_readout (.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
        .hw_sleep_pin_n(pin_n), .adc_in(adc_in), .adc_start(adc_start),
        .adc_abort(adc_abort), .alarm_open(alarm_open), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe));
    tsr_host_model u_tsr_host_model (.lclk(link_clk), .sda(sda), .scl_low(scl_low),
        .sda_low(sda_low));
    ////////////////////////////////////////
    // integer model of results
    task automatic model(input tsr_adc_t a);
        int l, m, ok, flt;
        l = $signed(a.local_res);
        m = $signed(a.remote_res);
        ok = int'(rate <= 6);
        flt = int'(a.fault_open || a.fault_short);
        expv[0] = (l >>> 3) & 255;
        expv[1] = flt ? 128 : (m >>> 3) & 255;
        expv[2] = ok ? (l & 7) << 5 : 0;
        expv[3] = (ok && !flt) ? (m & 7) << 5 : 0;
        exp_open = int'(a.fault_open);
    endtask
    // converter: done after conv_len cycles unless aborted
    always @(posedge mclk) begin
        adc_in.done <= (cnt == 1) && !adc_abort;
        if (adc_abort) cnt <= 0;
        else if (adc_start) cnt <= conv_len;
        else if (cnt > 0) cnt <= cnt - 1;
        starts <= starts + int'(adc_start);
        aborts <= aborts + int'(adc_abort);
        if (adc_in.done) model(adc_in);
    end
    // run ceiling in system clocks
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            failures++;
            conclude;
        end
    end
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // read results, status and alarm
    task automatic check_all;
        for (int i = 0; i < 4; i++) begin
            u_tsr_host_model.rd(offs[i], r);
            chk("result", r, expv[i]);
        end
        u_tsr_host_model.rd(OFS_STATUS, r);
        chk("status", r, exp_open << STAT_OPEN_BIT);
        chk("alarm", alarm_open, exp_open);
    endtask
    // one-shot conversion on random values
    task automatic convert(input logic fo, input logic fs);
        n0 = starts;
        @(posedge mclk);
        adc_in.local_res <= 11'($random(seed));
        adc_in.remote_res <= 11'($random(seed));
        adc_in.fault_open <= fo;
        adc_in.fault_short <= fs;
        u_tsr_host_model.send(OFS_ONESHOT, 8'h00, 1'b0);
        for (int t = 0; t < 400 && !(starts > n0 && cnt == 0); t++) @(posedge mclk);
        chk("starts", starts, n0 + 1);
    endtask
    ////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        pin_n = 1'b0;
        adc_in = '0;
        {seed, cnt, starts, aborts, failures, compares, cyc} = {32'd6, 192'd0};
        conv_len = 20;
        rate = 8;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge link_clk);
        u_tsr_host_model.rx(r);
        chk("receive", r, 8'h00);
        u_tsr_host_model.rd(OFS_STATUS, r);
        chk("status", r, 8'h00);
        u_tsr_host_model.send(OFS_CFG_WR, 8'h40, 1'b1);
        u_tsr_host_model.rd(OFS_CFG_RD, r);
        chk("config", r, 8'h40);
        u_tsr_host_model.rx(r);
        chk("receive", r, 8'h40);
        @(posedge mclk);
        pin_n <= 1'b1;
        repeat (40) @(posedge mclk);
        chk("standby", starts, 0);
        for (int k = 0; k < 4; k++) begin
            if (k == 1) begin
                u_tsr_host_model.send(OFS_RATE_WR, RATE_EXT_MAX, 1'b1);
                rate = 6;
            end
            convert(k == 3, k == 2);
            check_all;
        end
        // long conversion: busy, ignored one-shot, then pin low aborts
        conv_len = 8000;
        @(posedge mclk);
        adc_in.local_res <= ~adc_in.local_res;
        adc_in.remote_res <= ~adc_in.remote_res;
        adc_in.fault_open <= 1'b0;
        n0 = starts;
        u_tsr_host_model.send(OFS_ONESHOT, 8'h00, 1'b0);
        u_tsr_host_model.rd(OFS_STATUS, r);
        chk("busy", r, 8'h80 | (exp_open << STAT_OPEN_BIT));
        u_tsr_host_model.send(OFS_ONESHOT, 8'h00, 1'b0);
        @(posedge mclk);
        pin_n <= 1'b0;
        for (int t = 0; t < 50 && cnt != 0; t++) @(posedge mclk);
        chk("abort", aborts, 1);
        check_all;
        u_tsr_host_model.send(OFS_ONESHOT, 8'h00, 1'b0);
        @(posedge mclk);
        pin_n <= 1'b1;
        repeat (40) @(posedge mclk);
        chk("starts", starts, n0 + 1);
        u_tsr_host_model.start;
        u_tsr_host_model.tx({SLAVE_ADDR ^ 7'h10, 1'b1});
        u_tsr_host_model.stop;
        chk("nacks", u_tsr_host_model.nacks, 1);
        conclude;
    end
endmodule
